// file: rtl/acr_cfg.svh
// Purpose: Constants of the codec control register bank
// Assumes: Included by the serial receiver and top-level design files of the bank
// Notes: Definitions only
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

// ============================================================
// Register indices (serial select field values)
`define ACR_IDX_PWR 2'h0
`define ACR_IDX_MODE 2'h1
`define ACR_IDX_PCM 2'h2
`define ACR_IDX_SIDE 2'h3
`define ACR_NUM_REGS 4

// ============================================================
// Reset values
`define ACR_RST_PWR 8'h00
`define ACR_RST_MODE 8'h00
`define ACR_RST_PCM 8'h33
`define ACR_RST_SIDE 8'h00

// ============================================================
// Field positions
`define ACR_PWR_PDN 5
`define ACR_MODE_HI 7
`define ACR_MODE_LO 6
`define ACR_MODE_TXRST 5
`define ACR_MODE_RXRST 4
`define ACR_MODE_TXMUTE 3
`define ACR_MODE_RXMUTE 2
`define ACR_MODE_RXPAD 0
`define ACR_PCM_TXOFF 7
`define ACR_PCM_TXG_MSB 6
`define ACR_PCM_TXG_LSB 4
`define ACR_PCM_RXOFF 3
`define ACR_PCM_RXG_MSB 2
`define ACR_PCM_RXG_LSB 0
`define ACR_SIDE_G_MSB 7
`define ACR_SIDE_G_LSB 5
`define ACR_SIDE_HPSEL 1
`define ACR_SIDE_HPBYP 0

// ============================================================
// Serial frame
`define ACR_FRAME_SHORT 5'h0C
`define ACR_FRAME_LONG 5'h10
`define ACR_FRAME_MAX 5'h11
`define ACR_SEL_LIMIT 8'h04
`define ACR_SYNC_IDLE 4'hC

// ============================================================
// Decoded values
`define ACR_GAIN_OFS 5'h06
`define ACR_SIDE_OFS 6'h17
`define ACR_SIDE_OFF 3'h0
`define ACR_HPF_RATIO_LO 9'h113
`define ACR_HPF_RATIO_HI 9'h0C8
`define ACR_PAD_DB 4'hC
`define ACR_BITS_W4 4'h4
`define ACR_BITS_W8 4'h8
`define ACR_BITS_W3 4'h3
`define ACR_BITS_W2 4'h2

`endif

// file: rtl/acr_pkg.sv
// Purpose: Types of the codec control register bank
// Assumes: Nothing
// Notes: Values live in acr_cfg.svh
package acr_pkg;

  // ==========================================================
  // Coder word width selection
  typedef enum logic [1:0] {
    ACR_W4 = 2'b00,
    ACR_W8 = 2'b01,
    ACR_W3 = 2'b10,
    ACR_W2 = 2'b11
  } acr_width_type;

  // ==========================================================
  // Serial receiver state
  typedef enum logic {
    ACR_RX_IDLE = 1'b0,
    ACR_RX_SHIFT = 1'b1
  } acr_rx_state_type;

endpackage

// file: rtl/acr_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: async_i comes from outside the clock domain
// Notes: Level changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module acr_sync
  import acr_pkg::*;
#(
  parameter logic IDLE = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic level_o
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // ==========================================================
  // Sampling chain; s1 feeds only s2
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg <= IDLE;
      s2_reg <= IDLE;
      s3_reg <= IDLE;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Filtered level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= IDLE;
    end else if (s2_reg == s3_reg) begin
      level_o <= s3_reg;
    end
  end

endmodule // acr_sync
`default_nettype wire

// file: rtl/acr_serial_rx.sv
// Purpose: Serial control port frame receiver
// Assumes: Inputs already synchronised to clk_i
// Notes: MSB first, bit taken on shift clock rising edge
`timescale 1ns/10ps
`default_nettype none
`include "acr_cfg.svh"
module acr_serial_rx
  import acr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic fen_n_i,
  input wire logic sdat_i,
  output logic wr_o,
  output logic [1:0] sel_o,
  output logic [7:0] data_o,
  output logic err_o
);

  acr_rx_state_type state_reg;
  logic sclk_d_reg;
  logic [15:0] shift_reg;
  logic [4:0] count_reg;
  logic [7:0] sel_field;
  logic len_ok;
  logic sclk_rise;

  assign sclk_rise = sclk_i & ~sclk_d_reg;
  // Select field sits just above the data byte
  assign sel_field = (count_reg == `ACR_FRAME_SHORT) ?
                     {4'h0, shift_reg[11:8]} : shift_reg[15:8];
  assign len_ok = (count_reg == `ACR_FRAME_SHORT) ||
                  (count_reg == `ACR_FRAME_LONG);

  // ==========================================================
  // Edge detector for the sampled shift clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_i;
    end
  end

  // Frame state, bit shifting and counting
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ACR_RX_IDLE;
      shift_reg <= 16'h0000;
      count_reg <= 5'h00;
    end else begin
      unique case (state_reg)
        ACR_RX_IDLE: begin
          count_reg <= 5'h00;
          if (!fen_n_i) begin
            state_reg <= ACR_RX_SHIFT;
          end
        end
        ACR_RX_SHIFT: begin
          if (fen_n_i) begin
            state_reg <= ACR_RX_IDLE;
          end else if (sclk_rise) begin
            shift_reg <= {shift_reg[14:0], sdat_i};
            if (count_reg != `ACR_FRAME_MAX) begin
              count_reg <= count_reg + 5'h01;
            end
          end
        end
      endcase
    end
  end

  // Write only once the frame has closed
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_o <= 1'b0;
      err_o <= 1'b0;
      sel_o <= 2'h0;
      data_o <= 8'h00;
    end else begin
      wr_o <= 1'b0;
      err_o <= 1'b0;
      if (state_reg == ACR_RX_SHIFT && fen_n_i) begin
        if (len_ok && sel_field < `ACR_SEL_LIMIT) begin
          wr_o <= 1'b1;
          sel_o <= sel_field[1:0];
          data_o <= shift_reg[7:0];
        end else begin
          err_o <= 1'b1;
        end
      end
    end
  end

endmodule // acr_serial_rx
`default_nettype wire

// file: rtl/acr_top.sv
// Purpose: Control register bank of a voice ADPCM codec
// Assumes: Pins are asynchronous to REF_CLK_I
// Notes: Writes arrive over the serial control port
`timescale 1ns/10ps
`default_nettype none
`include "acr_cfg.svh"
module acr_top
  import acr_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic POWER_DOWN_RESET_PIN_N_I,
  input wire logic CONTROL_SHIFT_CLOCK_I,
  input wire logic CONTROL_FRAME_ENABLE_N_I,
  input wire logic CONTROL_DATA_I,
  input wire logic SAMPLE_SYNC_I,
  output logic POWER_DOWN_O,
  output logic [1:0] CODER_WIDTH_O,
  output logic [3:0] ADPCM_BITS_O,
  output logic TX_CODER_RESET_O,
  output logic RX_CODER_RESET_O,
  output logic TX_MUTE_O,
  output logic RX_MUTE_O,
  output logic RX_PAD_O,
  output logic [3:0] RX_PAD_DB_O,
  output logic TX_PCM_ENABLE_O,
  output logic RX_PCM_ENABLE_O,
  output logic [2:0] TX_GAIN_CODE_O,
  output logic [2:0] RX_GAIN_CODE_O,
  output logic [4:0] TX_GAIN_DB_O,
  output logic [4:0] RX_GAIN_DB_O,
  output logic [2:0] SIDETONE_GAIN_CODE_O,
  output logic SIDETONE_ENABLE_O,
  output logic [5:0] SIDETONE_GAIN_DB_O,
  output logic HIGHPASS_CUTOFF_SELECT_O,
  output logic [8:0] HIGHPASS_RATIO_O,
  output logic HIGHPASS_ENABLE_O,
  output logic [7:0] POWER_CONTROL_O,
  output logic [7:0] CODER_MODE_CONTROL_O,
  output logic [7:0] PCM_PATH_GAIN_CONTROL_O,
  output logic [7:0] SIDETONE_FILTER_CONTROL_O,
  output logic UPDATE_PENDING_O,
  output logic SETTINGS_APPLIED_O,
  output logic FRAME_ERROR_O
);

  // ==========================================================
  // Pin synchronisers
  logic [3:0] pin_raw;
  logic [3:0] pin_lvl;
  logic pdn_pin_n;
  logic sclk_lvl;
  logic fen_n_lvl;
  logic sync_lvl;
  logic sdat_lvl;
  logic sdat_s1_reg;
  logic sdat_s2_reg;

  assign pin_raw = {CONTROL_FRAME_ENABLE_N_I, POWER_DOWN_RESET_PIN_N_I,
                    SAMPLE_SYNC_I, CONTROL_SHIFT_CLOCK_I};
  assign sclk_lvl = pin_lvl[0];
  assign sync_lvl = pin_lvl[1];
  assign pdn_pin_n = pin_lvl[2];
  assign fen_n_lvl = pin_lvl[3];

  // Idle level of each pin, so no false edge or frame follows reset
  localparam logic [3:0] sync_idle = `ACR_SYNC_IDLE;

  // One filtered synchroniser per control pin other than the data pin
  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      acr_sync #(
        .IDLE(sync_idle[i])
      ) u_sync (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESET_N_I),
        .async_i(pin_raw[i]),
        .level_o(pin_lvl[i])
      );
    end
  endgenerate

  // Data pin through two plain flops, two cycles ahead of the filtered shift clock
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sdat_s1_reg <= 1'b0;
      sdat_s2_reg <= 1'b0;
    end else begin
      sdat_s1_reg <= CONTROL_DATA_I;
      sdat_s2_reg <= sdat_s1_reg;
    end
  end

  assign sdat_lvl = sdat_s2_reg;

  // ==========================================================
  // Serial control port
  logic wr;
  logic [1:0] wr_sel;
  logic [7:0] wr_data;
  logic frame_err;

  acr_serial_rx u_rx (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESET_N_I),
    .sclk_i(sclk_lvl),
    .fen_n_i(fen_n_lvl),
    .sdat_i(sdat_lvl),
    .wr_o(wr),
    .sel_o(wr_sel),
    .data_o(wr_data),
    .err_o(frame_err)
  );

  // ==========================================================
  // Register storage
  logic [7:0] stage_reg [0:`ACR_NUM_REGS-1];
  logic [7:0] act_reg [0:`ACR_NUM_REGS-1];
  // Reset value of each register, by index
  localparam logic [7:0] rst_val [0:`ACR_NUM_REGS-1] = '{
    `ACR_RST_PWR, `ACR_RST_MODE, `ACR_RST_PCM, `ACR_RST_SIDE};
  logic pending_reg;
  logic pending_next;
  logic sync_d_reg;
  logic apply;

  // Sample boundary detector
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sync_d_reg <= 1'b0;
    end else begin
      sync_d_reg <= sync_lvl;
    end
  end

  assign apply = sync_lvl & ~sync_d_reg;

  // Written image; test bits kept as written
  generate
    for (genvar r = 0; r < `ACR_NUM_REGS; r++) begin : g_reg
      always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
          stage_reg[r] <= rst_val[r];
        end else if (!pdn_pin_n) begin
          stage_reg[r] <= rst_val[r];
        end else if (wr && wr_sel == 2'(r)) begin
          stage_reg[r] <= wr_data;
        end
      end

      // Active image follows at the sample boundary; the power register follows at once
      always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
          act_reg[r] <= rst_val[r];
        end else if (!pdn_pin_n) begin
          act_reg[r] <= rst_val[r];
        end else if (2'(r) == `ACR_IDX_PWR || apply) begin
          act_reg[r] <= stage_reg[r];
        end
      end
    end
  endgenerate

  // Pending flag; a new write wins over the apply
  always_comb begin
    pending_next = pending_reg;
    if (apply) begin
      pending_next = 1'b0;
    end
    if (wr && wr_sel != `ACR_IDX_PWR) begin
      pending_next = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pending_reg <= 1'b0;
    end else if (!pdn_pin_n) begin
      pending_reg <= 1'b0;
    end else begin
      pending_reg <= pending_next;
    end
  end

  // ==========================================================
  // Field decoders
  logic [7:0] pwr;
  logic [7:0] mode;
  logic [7:0] pcm;
  logic [7:0] side;
  logic [2:0] txg;
  logic [2:0] rxg;
  logic [2:0] stg;
  acr_width_type width;
  logic [3:0] bits;

  assign pwr = act_reg[`ACR_IDX_PWR];
  assign mode = act_reg[`ACR_IDX_MODE];
  assign pcm = act_reg[`ACR_IDX_PCM];
  assign side = act_reg[`ACR_IDX_SIDE];
  assign txg = pcm[`ACR_PCM_TXG_MSB:`ACR_PCM_TXG_LSB];
  assign rxg = pcm[`ACR_PCM_RXG_MSB:`ACR_PCM_RXG_LSB];
  assign stg = side[`ACR_SIDE_G_MSB:`ACR_SIDE_G_LSB];
  assign width = acr_width_type'({mode[`ACR_MODE_HI],
                                  mode[`ACR_MODE_LO]});

  // Coder word size per sample
  always_comb begin
    unique case (width)
      ACR_W4: bits = `ACR_BITS_W4;
      ACR_W8: bits = `ACR_BITS_W8;
      ACR_W3: bits = `ACR_BITS_W3;
      ACR_W2: bits = `ACR_BITS_W2;
    endcase
  end

  // Gain code to dB, two's complement
  function automatic logic [4:0] gain_db(input logic [2:0] c);
    gain_db = {1'b0, c, 1'b0} - `ACR_GAIN_OFS;
  endfunction

  // ==========================================================
  // Power-down output
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      POWER_DOWN_O <= 1'b1;
    end else begin
      POWER_DOWN_O <= pwr[`ACR_PWR_PDN] | ~pdn_pin_n;
    end
  end

  // Coder controls
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      CODER_WIDTH_O <= 2'h0;
      ADPCM_BITS_O <= `ACR_BITS_W4;
      TX_CODER_RESET_O <= 1'b0;
      RX_CODER_RESET_O <= 1'b0;
      TX_MUTE_O <= 1'b0;
      RX_MUTE_O <= 1'b0;
      RX_PAD_O <= 1'b0;
      RX_PAD_DB_O <= 4'h0;
    end else begin
      CODER_WIDTH_O <= width;
      ADPCM_BITS_O <= bits;
      TX_CODER_RESET_O <= mode[`ACR_MODE_TXRST];
      RX_CODER_RESET_O <= mode[`ACR_MODE_RXRST];
      TX_MUTE_O <= mode[`ACR_MODE_TXMUTE];
      RX_MUTE_O <= mode[`ACR_MODE_RXMUTE];
      RX_PAD_O <= mode[`ACR_MODE_RXPAD];
      RX_PAD_DB_O <= mode[`ACR_MODE_RXPAD] ? `ACR_PAD_DB : 4'h0;
    end
  end

  // PCM paths and gains
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      TX_PCM_ENABLE_O <= 1'b1;
      RX_PCM_ENABLE_O <= 1'b1;
      TX_GAIN_CODE_O <= 3'h3;
      RX_GAIN_CODE_O <= 3'h3;
      TX_GAIN_DB_O <= 5'h00;
      RX_GAIN_DB_O <= 5'h00;
    end else begin
      TX_PCM_ENABLE_O <= ~pcm[`ACR_PCM_TXOFF];
      RX_PCM_ENABLE_O <= ~pcm[`ACR_PCM_RXOFF];
      TX_GAIN_CODE_O <= txg;
      RX_GAIN_CODE_O <= rxg;
      TX_GAIN_DB_O <= gain_db(txg);
      RX_GAIN_DB_O <= gain_db(rxg);
    end
  end

  // Side tone and high-pass filter
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SIDETONE_GAIN_CODE_O <= 3'h0;
      SIDETONE_ENABLE_O <= 1'b0;
      SIDETONE_GAIN_DB_O <= 6'h00;
      HIGHPASS_CUTOFF_SELECT_O <= 1'b0;
      HIGHPASS_RATIO_O <= `ACR_HPF_RATIO_LO;
      HIGHPASS_ENABLE_O <= 1'b1;
    end else begin
      SIDETONE_GAIN_CODE_O <= stg;
      SIDETONE_ENABLE_O <= (stg != `ACR_SIDE_OFF);
      if (stg == `ACR_SIDE_OFF) begin
        SIDETONE_GAIN_DB_O <= 6'h00;
      end else begin
        SIDETONE_GAIN_DB_O <= {2'b00, stg, 1'b0} - `ACR_SIDE_OFS;
      end
      HIGHPASS_CUTOFF_SELECT_O <= side[`ACR_SIDE_HPSEL];
      HIGHPASS_RATIO_O <= side[`ACR_SIDE_HPSEL] ?
                          `ACR_HPF_RATIO_HI : `ACR_HPF_RATIO_LO;
      HIGHPASS_ENABLE_O <= ~side[`ACR_SIDE_HPBYP];
    end
  end

  // Register images and status
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      POWER_CONTROL_O <= `ACR_RST_PWR;
      CODER_MODE_CONTROL_O <= `ACR_RST_MODE;
      PCM_PATH_GAIN_CONTROL_O <= `ACR_RST_PCM;
      SIDETONE_FILTER_CONTROL_O <= `ACR_RST_SIDE;
      UPDATE_PENDING_O <= 1'b0;
      SETTINGS_APPLIED_O <= 1'b0;
      FRAME_ERROR_O <= 1'b0;
    end else begin
      POWER_CONTROL_O <= pwr;
      CODER_MODE_CONTROL_O <= mode;
      PCM_PATH_GAIN_CONTROL_O <= pcm;
      SIDETONE_FILTER_CONTROL_O <= side;
      UPDATE_PENDING_O <= pending_reg;
      SETTINGS_APPLIED_O <= apply & pending_reg & pdn_pin_n;
      FRAME_ERROR_O <= frame_err;
    end
  end

endmodule // acr_top
`default_nettype wire

// file: testbench/acr_chk.sv
// Purpose: Port assertions of the codec control register bank
// Assumes: Bound to acr_top, sees only its ports
// Notes: Decodes are checked in the same cycle as the active images
`timescale 1ns/10ps
`default_nettype none
module acr_chk
  import acr_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic POWER_DOWN_RESET_PIN_N_I,
  input wire logic SAMPLE_SYNC_I,
  input wire logic POWER_DOWN_O,
  input wire logic [1:0] CODER_WIDTH_O,
  input wire logic [3:0] ADPCM_BITS_O,
  input wire logic TX_CODER_RESET_O,
  input wire logic RX_CODER_RESET_O,
  input wire logic TX_MUTE_O,
  input wire logic RX_MUTE_O,
  input wire logic RX_PAD_O,
  input wire logic TX_PCM_ENABLE_O,
  input wire logic RX_PCM_ENABLE_O,
  input wire logic [4:0] TX_GAIN_DB_O,
  input wire logic [4:0] RX_GAIN_DB_O,
  input wire logic [5:0] SIDETONE_GAIN_DB_O,
  input wire logic [8:0] HIGHPASS_RATIO_O,
  input wire logic HIGHPASS_ENABLE_O,
  input wire logic [7:0] POWER_CONTROL_O,
  input wire logic [7:0] CODER_MODE_CONTROL_O,
  input wire logic [7:0] PCM_PATH_GAIN_CONTROL_O,
  input wire logic [7:0] SIDETONE_FILTER_CONTROL_O,
  input wire logic UPDATE_PENDING_O,
  input wire logic SETTINGS_APPLIED_O,
  input wire logic FRAME_ERROR_O
);
  // ==========================================================
  // Helper counters
  logic [2:0] run_cnt;
  logic [2:0] pin_cnt;
  wire logic ok = run_cnt == 3'h7 && pin_cnt == 3'h7;
  // Cycles since reset release, saturating
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) run_cnt <= 3'h0;
    else if (run_cnt != 3'h7) run_cnt <= run_cnt + 3'h1;
  end
  // Cycles with the power-down pin high, saturating
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) pin_cnt <= 3'h0;
    else if (!POWER_DOWN_RESET_PIN_N_I) pin_cnt <= 3'h0;
    else if (pin_cnt != 3'h7) pin_cnt <= pin_cnt + 3'h1;
  end
  // Word size of each width code
  function automatic logic [3:0] bits_of(input logic [1:0] w);
    return (w == 2'h0) ? 4'h4 : (w == 2'h1) ? 4'h8 :
      (w == 2'h2) ? 4'h3 : 4'h2;
  endfunction
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_pin_low;
    !POWER_DOWN_RESET_PIN_N_I [*6];
  endsequence
  sequence s_pend_sync;
    (UPDATE_PENDING_O && $rose(SAMPLE_SYNC_I)) ##1
      POWER_DOWN_RESET_PIN_N_I [*3];
  endsequence
  // ==========================================================
  // Assertions
  a_pdn_bit: assert property (
    run_cnt == 3'h7 && POWER_CONTROL_O[5] |-> POWER_DOWN_O)
    else $error("power-down bit set but not powered down");
  a_pdn_pin: assert property (s_pin_low |=> POWER_DOWN_O)
    else $error("pin low but not powered down");
  a_pdn_off: assert property (
    (run_cnt == 3'h7 && POWER_DOWN_RESET_PIN_N_I &&
    !POWER_CONTROL_O[5]) [*7] |-> !POWER_DOWN_O)
    else $error("powered down with bit and pin released");
  a_pin_reset: assert property (s_pin_low |=>
    {POWER_CONTROL_O, CODER_MODE_CONTROL_O, PCM_PATH_GAIN_CONTROL_O,
    SIDETONE_FILTER_CONTROL_O} == 32'h00003300)
    else $error("pin reset left wrong images");
  a_mode_dec: assert property (
    run_cnt == 3'h7 |-> CODER_WIDTH_O == CODER_MODE_CONTROL_O[7:6]
    && ADPCM_BITS_O == bits_of(CODER_MODE_CONTROL_O[7:6]) &&
    {TX_CODER_RESET_O, RX_CODER_RESET_O, TX_MUTE_O, RX_MUTE_O, RX_PAD_O}
    == {CODER_MODE_CONTROL_O[5:2], CODER_MODE_CONTROL_O[0]})
    else $error("coder mode outputs disagree with image");
  a_pcm_dec: assert property (
    run_cnt == 3'h7 |-> TX_PCM_ENABLE_O == !PCM_PATH_GAIN_CONTROL_O[7]
    && RX_PCM_ENABLE_O == !PCM_PATH_GAIN_CONTROL_O[3] &&
    TX_GAIN_DB_O == {1'b0, PCM_PATH_GAIN_CONTROL_O[6:4], 1'b0} - 5'h06
    && RX_GAIN_DB_O == {1'b0, PCM_PATH_GAIN_CONTROL_O[2:0], 1'b0}
    - 5'h06)
    else $error("path and gain outputs disagree with image");
  a_side_dec: assert property (
    run_cnt == 3'h7 |-> SIDETONE_GAIN_DB_O ==
    (SIDETONE_FILTER_CONTROL_O[7:5] == 3'h0 ? 6'h00 :
    {2'b00, SIDETONE_FILTER_CONTROL_O[7:5], 1'b0} - 6'h17) &&
    HIGHPASS_ENABLE_O == !SIDETONE_FILTER_CONTROL_O[0] &&
    HIGHPASS_RATIO_O == (SIDETONE_FILTER_CONTROL_O[1] ? 9'h0C8 : 9'h113))
    else $error("side-tone and filter outputs disagree with image");
  a_chg_pend: assert property (ok && $changed({CODER_MODE_CONTROL_O,
    PCM_PATH_GAIN_CONTROL_O, SIDETONE_FILTER_CONTROL_O})
    |-> $past(UPDATE_PENDING_O))
    else $error("image changed without a pending update");
  a_apply_pend: assert property (SETTINGS_APPLIED_O |->
    UPDATE_PENDING_O ##1 !SETTINGS_APPLIED_O)
    else $error("apply pulse without pending update");
  a_apply_wait: assert property (s_pend_sync |->
    ##[1:8] SETTINGS_APPLIED_O)
    else $error("pending update not applied at sample boundary");
  a_err_pulse: assert property (FRAME_ERROR_O |=> !FRAME_ERROR_O)
    else $error("frame error longer than one cycle");
endmodule // acr_chk
`default_nettype wire

// file: testbench/acr_host_model.sv
// Purpose: Host controller driving the serial control port
// Assumes: send is called just after a falling system clock edge
// Notes: Shift clock stands low outside frames, 160 ns period
`timescale 1ns/10ps
`default_nettype none
module acr_host_model (
  input wire logic clk_i,
  output logic sclk_o,
  output logic fen_n_o,
  output logic sdat_o
);
  // ==========================================================
  // Idle levels
  initial begin
    sclk_o = 1'b0;
    fen_n_o = 1'b1;
    sdat_o = 1'b0;
  end
  // Wait n falling system clock edges
  task automatic gap(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // One frame of n bits, MSB first, bit taken on shift clock rise
  task automatic send(input int n, input logic [15:0] w);
    fen_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdat_o = w[i];
      gap(4);
      sclk_o = 1'b1;
      gap(4);
      sclk_o = 1'b0;
    end
    gap(4);
    fen_n_o = 1'b1;
    sdat_o = ~sdat_o; // Released data line shows the inverse level
    gap(8);
  endtask
endmodule // acr_host_model
`default_nettype wire

// file: testbench/tb_acr_top.sv
// Purpose: Self-checking bench of the codec control register bank
// Assumes: Host model drives the serial port
// Notes: One sample period of the bench is one apply call
`timescale 1ns/10ps
`default_nettype none
module tb_acr_top;
  import acr_pkg::*;
  // ==========================================================
  // Signals named as the design ports
  logic REF_CLK_I, RESET_N_I, POWER_DOWN_RESET_PIN_N_I, SAMPLE_SYNC_I;
  logic CONTROL_SHIFT_CLOCK_I, CONTROL_FRAME_ENABLE_N_I, CONTROL_DATA_I;
  logic POWER_DOWN_O, TX_CODER_RESET_O, RX_CODER_RESET_O, TX_MUTE_O;
  logic RX_MUTE_O, RX_PAD_O, TX_PCM_ENABLE_O, RX_PCM_ENABLE_O;
  logic SIDETONE_ENABLE_O, HIGHPASS_CUTOFF_SELECT_O, HIGHPASS_ENABLE_O;
  logic UPDATE_PENDING_O, SETTINGS_APPLIED_O, FRAME_ERROR_O;
  logic [1:0] CODER_WIDTH_O;
  logic [2:0] TX_GAIN_CODE_O, RX_GAIN_CODE_O, SIDETONE_GAIN_CODE_O;
  logic [3:0] ADPCM_BITS_O, RX_PAD_DB_O;
  logic [4:0] TX_GAIN_DB_O, RX_GAIN_DB_O;
  logic [5:0] SIDETONE_GAIN_DB_O;
  logic [8:0] HIGHPASS_RATIO_O;
  logic [7:0] POWER_CONTROL_O, CODER_MODE_CONTROL_O;
  logic [7:0] PCM_PATH_GAIN_CONTROL_O, SIDETONE_FILTER_CONTROL_O;
  int err_count = 0;
  int tests_run = 0;
  int fe_cnt = 0;
  int ap_cnt = 0;
  acr_top i_acr_top (.*);
  acr_host_model i_acr_host_model (
    .clk_i(REF_CLK_I),
    .sclk_o(CONTROL_SHIFT_CLOCK_I),
    .fen_n_o(CONTROL_FRAME_ENABLE_N_I),
    .sdat_o(CONTROL_DATA_I)
  );
  // Clock, frame error pulse counter and apply pulse counter
  initial begin
    REF_CLK_I = 1'b0;
    forever #10 REF_CLK_I = ~REF_CLK_I;
  end
  always @(posedge REF_CLK_I) if (FRAME_ERROR_O === 1'b1) fe_cnt++;
  always @(posedge REF_CLK_I) if (SETTINGS_APPLIED_O === 1'b1) ap_cnt++;
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge REF_CLK_I);
  endtask
  task automatic wr(input int n, input logic [7:0] sel, d);
    i_acr_host_model.send(n, n == 12 ? {4'h0, sel[3:0], d} : {sel, d});
    cyc(4);
  endtask
  // One sample boundary, long enough to count as a sample period
  task automatic apply();
    SAMPLE_SYNC_I = 1'b1;
    cyc(6);
    SAMPLE_SYNC_I = 1'b0;
    cyc(6);
  endtask
  task automatic summarize();
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    POWER_DOWN_RESET_PIN_N_I = 1'b0;
    cyc(10);
    chk("pd_pin", POWER_DOWN_O, 1'b1);
    POWER_DOWN_RESET_PIN_N_I = 1'b1;
    cyc(10);
    chk("images", {POWER_CONTROL_O, CODER_MODE_CONTROL_O,
      PCM_PATH_GAIN_CONTROL_O, SIDETONE_FILTER_CONTROL_O}, 32'h00003300);
    chk("pd_off", POWER_DOWN_O, 1'b0);
    chk("pcm", {TX_PCM_ENABLE_O, RX_PCM_ENABLE_O, TX_GAIN_DB_O,
      RX_GAIN_DB_O}, 12'hC00);
    chk("hpf", {HIGHPASS_ENABLE_O, HIGHPASS_RATIO_O,
      SIDETONE_ENABLE_O}, 11'h626);
  endtask
  task automatic t_power();
    wr(12, 8'h00, 8'h20);
    chk("pd_bit", POWER_DOWN_O, 1'b1);
    chk("pwr_img", POWER_CONTROL_O, 8'h20);
    wr(16, 8'h00, 8'h00);
    chk("pd_clr", POWER_DOWN_O, 1'b0);
  endtask
  task automatic t_mode();
    logic [3:0] nb [4];
    logic [7:0] d;
    logic [7:0] prev;
    int a0;
    nb = '{4'h4, 4'h8, 4'h3, 4'h2};
    prev = 8'h00;
    for (int w = 0; w < 4; w++) begin
      d = {w[1:0], ~w[0], ~w[0], w[1], ~w[1], 1'b0, w[0]};
      wr(12, 8'h01, d);
      chk("pend", UPDATE_PENDING_O, 1'b1);
      chk("mode_old", CODER_MODE_CONTROL_O, prev);
      a0 = ap_cnt;
      apply();
      chk("applied", ap_cnt - a0, 1);
      chk("mode_img", CODER_MODE_CONTROL_O, d);
      chk("bits", {CODER_WIDTH_O, ADPCM_BITS_O}, {w[1:0], nb[w]});
      chk("ctl", {TX_CODER_RESET_O, RX_CODER_RESET_O, TX_MUTE_O,
        RX_MUTE_O, RX_PAD_O}, {d[5:2], d[0]});
      chk("pad", RX_PAD_DB_O, d[0] ? 4'hC : 4'h0);
      prev = d;
    end
  endtask
  task automatic t_gain();
    logic [2:0] g;
    for (int c = 0; c < 8; c++) begin
      g = c[2:0];
      wr(12, 8'h02, {g[0], g, ~g[0], ~g});
      wr(16, 8'h03, {g, 3'h0, g[1], g[0]});
      apply();
      chk("gcode", {TX_GAIN_CODE_O, RX_GAIN_CODE_O}, {g, ~g});
      chk("gdb", {TX_GAIN_DB_O, RX_GAIN_DB_O}, {5'(2 * c - 6),
        5'(8 - 2 * c)});
      chk("pcm_en", {TX_PCM_ENABLE_O, RX_PCM_ENABLE_O}, {~g[0], g[0]});
      chk("st", {SIDETONE_GAIN_CODE_O, SIDETONE_ENABLE_O, SIDETONE_GAIN_DB_O},
        {g, g != 3'h0, g == 3'h0 ? 6'h00 : 6'(2 * c - 23)});
      chk("hp", {HIGHPASS_CUTOFF_SELECT_O, HIGHPASS_RATIO_O,
        HIGHPASS_ENABLE_O}, {g[1], g[1] ? 9'h0C8 : 9'h113, ~g[0]});
    end
  endtask
  task automatic t_error();
    int fe0;
    fe0 = fe_cnt;
    wr(14, 8'h00, 8'h20);
    wr(12, 8'h04, 8'h20);
    wr(16, 8'h81, 8'h20);
    chk("fe_cnt", fe_cnt - fe0, 3);
    chk("pwr_kept", {POWER_CONTROL_O, POWER_DOWN_O}, 9'h000);
    chk("no_pend", UPDATE_PENDING_O, 1'b0);
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    RESET_N_I = 1'b0;
    POWER_DOWN_RESET_PIN_N_I = 1'b1;
    SAMPLE_SYNC_I = 1'b0;
    cyc(8);
    RESET_N_I = 1'b1;
    cyc(4);
    t_reset();
    t_power();
    t_mode();
    t_gain();
    t_error();
    t_reset();
    summarize();
  end
  initial begin
    #400000;
    err_count++;
    summarize();
  end
endmodule // tb_acr_top
bind acr_top acr_chk i_acr_chk (.*);
`default_nettype wire
